// file: asr_pkg.sv
// Package for the serial readout link of a sampling converter.
// Assumes a 40 MHz system clock at both ends and a link clock of about 5 MHz.
package asr_pkg;
    localparam int WORD_BITS         = 16;
    localparam int FRAME_BITS        = 32;
    localparam int CLOCK_MHZ         = 40;
    localparam int CYCLE_TIME_NS     = 1000;
    localparam int SAFE_PHASE_NS     = 500;
    localparam int QUIET_PHASE_NS    = 500;
    localparam int LATE_WINDOW_NS    = 150;
    localparam int APERTURE_NS       = 50;
    localparam int SAFE_CYCLES       = (SAFE_PHASE_NS * CLOCK_MHZ) / 1000;
    localparam int QUIET_CYCLES      = (QUIET_PHASE_NS * CLOCK_MHZ) / 1000;
    localparam int LATE_CYCLES       = (LATE_WINDOW_NS * CLOCK_MHZ) / 1000;
    localparam int APERTURE_CYCLES   = (APERTURE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int CONV_CYCLES       = SAFE_CYCLES + QUIET_CYCLES;
    localparam int SCK_HALF_DIV      = 4;
    localparam int PHASE_SEL_BIT     = 0;
    localparam int MODE_SEL_BIT      = 1;
    localparam int UPDATE_BIT        = 15;
    localparam logic [15:0] CFG_RESET = 16'h8fcf;
    localparam int DEPTH             = 16;

    typedef enum logic [1:0] {
        ASR_CONV_IDLE  = 2'b00,
        ASR_CONV_SAFE  = 2'b01,
        ASR_CONV_QUIET = 2'b10
    } asr_conv_t;

    typedef enum logic [2:0] {
        ASR_H_IDLE  = 3'b000,
        ASR_H_START = 3'b001,
        ASR_H_WAIT  = 3'b010,
        ASR_H_LOW   = 3'b011,
        ASR_H_HIGH  = 3'b100,
        ASR_H_DONE  = 3'b101
    } asr_host_t;
endpackage

// file: asr_link_if.sv
// Interface joining the converter end and the host end of the serial link.
// The interface itself resolves the data output wire from the enable.
`timescale 1ns/1ps
interface asr_link_if;
    logic conversion_start_strobe;
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo_out;
    logic sdo_oe_n;
    logic busy;
    logic sdo;

    // Pull the released line low; no high impedance in design code
    assign sdo = sdo_oe_n ? 1'b0 : sdo_out;

    modport converter (
        input  conversion_start_strobe,
        input  cs_n,
        input  sck,
        input  sdi,
        output sdo_out,
        output sdo_oe_n,
        output busy
    );
    modport host (
        output conversion_start_strobe,
        output cs_n,
        output sck,
        output sdi,
        input  sdo,
        input  busy
    );
endinterface

// file: asr_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; width and depth are parameters.
`timescale 1ns/1ps
module asr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// file: asr_converter.sv
// Converter end: conversion timing engine and serial readout/config port.
// Assumes link pins come from another domain and are synchronised here.
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Host captures output on falling clock edges
// - Falling-edge hosts stay inside safe window
// - Rising-edge hosts lengthen after-conversion window
// - Long transfers may split across conversions
// - Config word follows result, MSB first
// - Extra edges cycle result and config again
// - No link activity around the sampling edge
// - Conversion splits into safe and quiet halves
// - Full rate needs 34 MHz serial clock
// - Late window allows 25 MHz, discouraged
// - Slow host uses only after-conversion window
// - Chip select may span start; clock pauses
// - Split transfers end when late window closes; code restarts the frame at eoc
// - Long cycle time requires asynchronous mode
// - Result and config update at end-of-conversion
// - Access accepted while busy, through late window
// - Host gives 16 edges result, 16 config
// - Chip select free, held low, or tied
// - Output enabled by select; shift on falling edges
// - Phase bit one repeats MSB once
`timescale 1ns/1ps
module asr_converter
    import asr_pkg::*;
#(
    parameter int RESULT_BITS = asr_pkg::WORD_BITS
) (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    asr_link_if.converter                    link,
    input  wire logic [RESULT_BITS-1:0]      sample_value,
    output logic      [asr_pkg::WORD_BITS-1:0] active_config,
    output logic                             conversion_done
);
    import asr_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] stb_sync;
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] sdi_sync;
    logic       stb_prev;
    logic       sck_prev;
    logic       cs_prev;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stb_sync <= 2'h0;
            cs_sync  <= 2'h3;
            sck_sync <= 2'h0;
            sdi_sync <= 2'h0;
            stb_prev <= 1'b0;
            sck_prev <= 1'b0;
            cs_prev  <= 1'b1;
        end
        else if (ce)
        begin
            stb_sync <= {stb_sync[0], link.conversion_start_strobe};
            cs_sync  <= {cs_sync[0], link.cs_n};
            sck_sync <= {sck_sync[0], link.sck};
            sdi_sync <= {sdi_sync[0], link.sdi};
            stb_prev <= stb_sync[1];
            sck_prev <= sck_sync[1];
            cs_prev  <= cs_sync[1];
        end
    end

    logic stb_rise;
    logic sck_fall;
    logic sck_rise;
    logic cs_fall;
    logic selected;
    assign stb_rise = stb_sync[1] && !stb_prev;
    assign sck_fall = !sck_sync[1] && sck_prev;
    assign sck_rise = sck_sync[1] && !sck_prev;
    assign cs_fall  = !cs_sync[1] && cs_prev;
    assign selected = !cs_sync[1];

    // ****************************************************************
    // Conversion timing engine
    // ****************************************************************
    asr_conv_t   state;
    logic [15:0] phase_count;
    logic        eoc;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state       <= ASR_CONV_IDLE;
            phase_count <= 16'h0;
        end
        else if (ce)
        begin
            case (state)
                ASR_CONV_IDLE:
                    if (stb_rise)
                    begin
                        state       <= ASR_CONV_SAFE;
                        phase_count <= 16'h0;
                    end
                ASR_CONV_SAFE:
                    if (phase_count == 16'(SAFE_CYCLES - 1))
                    begin
                        state       <= ASR_CONV_QUIET;
                        phase_count <= 16'h0;
                    end
                    else
                        phase_count <= phase_count + 16'h1;
                ASR_CONV_QUIET:
                    if (phase_count == 16'(QUIET_CYCLES - 1))
                        state <= ASR_CONV_IDLE;
                    else
                        phase_count <= phase_count + 16'h1;
                default:
                    state <= ASR_CONV_IDLE;
            endcase
        end
    end

    // Start strobes during conversion are ignored by the idle-only decode
    assign eoc             = ce && (state == ASR_CONV_QUIET)
                             && (phase_count == 16'(QUIET_CYCLES - 1));
    assign link.busy       = (state != ASR_CONV_IDLE);
    assign conversion_done = eoc;

    // ****************************************************************
    // Result and configuration pipeline
    // ****************************************************************
    logic [WORD_BITS-1:0] cfg_shift;
    logic [4:0]           cfg_count;
    logic                 cfg_loaded;
    logic [WORD_BITS-1:0] cfg_pending;
    logic [WORD_BITS-1:0] cfg_of_result;
    logic [WORD_BITS-1:0] result;
    logic [WORD_BITS-1:0] held_sample;

    // Sample is held at the start so a drifting input cannot skew the word
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            held_sample <= 16'h0;
        else if (ce && stb_rise && state == ASR_CONV_IDLE)
            held_sample <= WORD_BITS'(sample_value);
    end

    // Two-deep pipeline: written word applies after two end-of-conversions
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_pending   <= CFG_RESET;
            active_config <= CFG_RESET;
            cfg_of_result <= CFG_RESET;
            result        <= 16'h0;
        end
        else if (eoc)
        begin
            result        <= held_sample;
            cfg_of_result <= active_config;
            active_config <= cfg_pending;
            if (cfg_loaded && cfg_shift[UPDATE_BIT])
                cfg_pending <= cfg_shift;
        end
    end

    // Config shifts in on rising edges; incomplete words are dropped at eoc
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_shift  <= 16'h0;
            cfg_count  <= 5'h0;
            cfg_loaded <= 1'b0;
        end
        else if (ce)
        begin
            if (eoc || cs_fall)
            begin
                cfg_count  <= 5'h0;
                cfg_loaded <= 1'b0;
            end
            else if (selected && sck_rise && cfg_count != 5'(WORD_BITS))
            begin
                cfg_shift <= {cfg_shift[WORD_BITS-2:0], sdi_sync[1]};
                cfg_count <= cfg_count + 5'h1;
                if (cfg_count == 5'(WORD_BITS - 1))
                    cfg_loaded <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Serial output sequencer
    // ****************************************************************
    logic [4:0] bit_index;
    logic       repeat_pending;
    logic       out_bit;
    logic       phase_sel;
    assign phase_sel = cfg_of_result[PHASE_SEL_BIT];

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_index      <= 5'h0;
            repeat_pending <= 1'b0;
        end
        else if (ce)
        begin
            if (cs_fall || eoc)
            begin
                bit_index      <= 5'h0;
                repeat_pending <= phase_sel;
            end
            else if (selected && sck_fall)
            begin
                if (repeat_pending)
                    repeat_pending <= 1'b0;
                else
                    bit_index <= bit_index + 5'h1;
            end
        end
    end

    // Frame is result then its config; 5-bit index wraps at 32
    always_comb
    begin
        if (bit_index < 5'(WORD_BITS))
            out_bit = result[WORD_BITS - 1 - int'(bit_index)];
        else
            out_bit = cfg_of_result[FRAME_BITS - 1 - int'(bit_index)];
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            link.sdo_out  <= 1'b0;
            link.sdo_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            link.sdo_out  <= out_bit;
            link.sdo_oe_n <= !selected;
        end
    end
    // Access while busy is accepted; nothing gates the port on state
endmodule

// file: asr_host.sv
// Host end: starts conversions, reads result plus config, writes config.
// Assumes a 40 MHz clock; makes the link clock by division.
`timescale 1ns/1ps
module asr_host
    import asr_pkg::*;
#(
    parameter int DEPTH = asr_pkg::DEPTH
) (
    input  wire logic                          clock,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    asr_link_if.host                           link,
    input  wire logic                          start,
    input  wire logic [asr_pkg::WORD_BITS-1:0] cfg_word,
    output logic                               frame_valid,
    input  wire logic                          frame_ready,
    output logic      [asr_pkg::FRAME_BITS-1:0] frame_data,
    output logic                               host_idle
);
    import asr_pkg::*;

    // ****************************************************************
    // Busy and data output synchroniser
    // ****************************************************************
    logic [1:0] busy_sync;
    logic [1:0] sdo_sync;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_sync <= 2'h0;
            sdo_sync  <= 2'h0;
        end
        else if (ce)
        begin
            busy_sync <= {busy_sync[0], link.busy};
            sdo_sync  <= {sdo_sync[0], link.sdo};
        end
    end

    // ****************************************************************
    // Transfer sequencer (read after conversion)
    // ****************************************************************
    asr_host_t                 state;
    logic [7:0]                div;
    logic [5:0]                edges;
    logic [FRAME_BITS-1:0]     shift_in;
    logic [WORD_BITS-1:0]      shift_out;
    logic                      fifo_ready;
    logic                      push;
    logic                      seen_busy;

    assign push      = (state == ASR_H_DONE) && fifo_ready;
    assign host_idle = (state == ASR_H_IDLE);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state                   <= ASR_H_IDLE;
            div                     <= 8'h0;
            edges                   <= 6'h0;
            shift_in                <= 32'h0;
            shift_out               <= 16'h0;
            seen_busy               <= 1'b0;
            link.conversion_start_strobe <= 1'b0;
            link.cs_n               <= 1'b1;
            link.sck                <= 1'b0;
            link.sdi                <= 1'b0;
        end
        else if (ce)
        begin
            case (state)
                ASR_H_IDLE:
                    if (start && fifo_ready)
                    begin
                        link.conversion_start_strobe <= 1'b1;
                        shift_out <= cfg_word;
                        seen_busy <= 1'b0;
                        state     <= ASR_H_START;
                    end
                ASR_H_START:
                    // No link activity until conversion ends
                    begin
                        if (busy_sync[1])
                            seen_busy <= 1'b1;
                        // Whole access after conversion, never split across a start
                        if (seen_busy && !busy_sync[1])
                        begin
                            link.conversion_start_strobe <= 1'b0;
                            link.cs_n <= 1'b0;
                            div       <= 8'h0;
                            edges     <= 6'h0;
                            state     <= ASR_H_WAIT;
                        end
                    end
                ASR_H_WAIT:
                    // Divided clock is far below full-rate needs, hence after-conversion access
                    if (div == 8'(SCK_HALF_DIV - 1))
                    begin
                        div      <= 8'h0;
                        link.sck <= 1'b1;
                        link.sdi <= shift_out[WORD_BITS-1];
                        state    <= ASR_H_HIGH;
                    end
                    else
                        div <= div + 8'h1;
                ASR_H_HIGH:
                    if (div == 8'(SCK_HALF_DIV - 1))
                    begin
                        // Capture on falling edge: sample the line before it moves
                        div      <= 8'h0;
                        link.sck <= 1'b0;
                        shift_in <= {shift_in[FRAME_BITS-2:0], sdo_sync[1]};
                        shift_out <= {shift_out[WORD_BITS-2:0], 1'b0};
                        edges    <= edges + 6'h1;
                        state    <= (edges == 6'(FRAME_BITS - 1)) ? ASR_H_DONE
                                                                  : ASR_H_WAIT;
                    end
                    else
                        div <= div + 8'h1;
                ASR_H_DONE:
                    begin
                        link.cs_n <= 1'b1;
                        if (fifo_ready)
                            state <= ASR_H_IDLE;
                    end
                default:
                    state <= ASR_H_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Frame buffer
    // ****************************************************************
    asr_fifo #(
        .WIDTH (FRAME_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (shift_in),
        .out_valid (frame_valid),
        .out_ready (frame_ready),
        .out_data  (frame_data)
    );
endmodule

// file: asr_link_checker.sv
// Assertions on the serial link between converter end and host end.
// Assumes one clock domain; inputs come straight from the interface.
`timescale 1ns/1ps
module asr_link_checker
    import asr_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic conversion_start_strobe,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire logic busy,
    input wire logic sdo
);
    // ********
    // Helpers
    // ********
    logic       sck_q;
    logic [7:0] busy_cnt;
    logic [7:0] rise_cnt;
    logic [7:0] since_fall;

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            sck_q <= 1'b0;
        else
            sck_q <= sck;

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            busy_cnt <= 8'h00;
        else
            busy_cnt <= busy ? busy_cnt + 8'h01 : 8'h00;

    // Rises counted, not falls: last fall may meet the select release
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            rise_cnt <= 8'h00;
        else if (cs_n)
            rise_cnt <= 8'h00;
        else if (sck && !sck_q)
            rise_cnt <= rise_cnt + 8'h01;

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            since_fall <= 8'hff;
        else if (sck_q && !sck)
            since_fall <= 8'h00;
        else if (since_fall != 8'hff)
            since_fall <= since_fall + 8'h01;

    // ********
    // Assertions
    // ********
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_release_deselect: assert property (cs_n [*6] |-> sdo_oe_n)
        else $error("data output driven while deselected");
    a_enable_select: assert property (!cs_n [*6] |-> !sdo_oe_n)
        else $error("data output not enabled while selected");
    a_bit_after_fall: assert property (!sdo_oe_n && !$past(sdo_oe_n, 3) && $changed(sdo_out)
        |-> since_fall <= 8'd10)
        else $error("data output changed without a clock fall");
    a_busy_length: assert property ($fell(busy) |-> busy_cnt == 8'(CONV_CYCLES))
        else $error("conversion length wrong");
    a_strobe_starts: assert property ($rose(conversion_start_strobe) && !busy
        |-> ##[2:5] busy)
        else $error("strobe did not start a conversion");
    a_quiet_sample: assert property ($rose(conversion_start_strobe)
        |-> (cs_n && !sck) [*3])
        else $error("link activity at sampling edge");
    a_access_after: assert property (busy |-> cs_n && !sck)
        else $error("link access during conversion");
    a_edge_count: assert property ($rose(cs_n) |-> rise_cnt == 8'(FRAME_BITS))
        else $error("frame clock count wrong");
endmodule

// file: tb_adc_serial_readout_timing.sv
// Bench: converter end facing host end over the link interface.
// Assumes package, interface, fifo and both ends compile first.
`timescale 1ns/1ps
module tb_adc_serial_readout_timing;
    import asr_pkg::*;
    logic        clock;
    logic        nrst;
    logic        ce;
    logic        start;
    logic [15:0] cfg_word;
    logic [15:0] sample_value;
    logic        frame_ready;
    logic        frame_valid;
    logic [31:0] frame_data;
    logic        host_idle;
    logic        conversion_done;
    int          dones = 0;
    int          starts = 0;
    logic [15:0] active_config;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n;
    logic [31:0] exp_q[$];
    logic [15:0] act;
    logic [15:0] pend;
    logic [15:0] wprev;
    logic        have_prev;
    logic        rand_ready;
    logic [15:0] corner_val[5] = '{16'hffff, 16'h0000, 16'h8000, 16'h0001, 16'h5a5a};
    logic [15:0] corner_cfg[5] = '{16'h8001, 16'h0000, 16'h8002, 16'h8000, 16'h8001};

    asr_link_if asr_link_if_i ();
    asr_converter asr_converter_i (.clock(clock), .nrst(nrst), .ce(ce),
        .link(asr_link_if_i), .sample_value(sample_value),
        .active_config(active_config), .conversion_done(conversion_done));
    asr_host asr_host_i (.clock(clock), .nrst(nrst), .ce(ce), .link(asr_link_if_i),
        .start(start), .cfg_word(cfg_word), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .frame_data(frame_data), .host_idle(host_idle));
    asr_link_checker asr_link_checker_i (.clock(clock), .nrst(nrst),
        .conversion_start_strobe(asr_link_if_i.conversion_start_strobe),
        .cs_n(asr_link_if_i.cs_n), .sck(asr_link_if_i.sck), .sdi(asr_link_if_i.sdi),
        .sdo_out(asr_link_if_i.sdo_out), .sdo_oe_n(asr_link_if_i.sdo_oe_n),
        .busy(asr_link_if_i.busy), .sdo(asr_link_if_i.sdo));

    // ********
    // Helpers
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Counts: %0d checks, %0d miscompares", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Phase bit set repeats the result MSB, pushing the last config bit out
    function automatic logic [31:0] frame_of(input logic [15:0] r, input logic [15:0] c);
        return c[PHASE_SEL_BIT] ? {r[15], r, c[15:1]} : {r, c};
    endfunction

    task automatic wait_idle();
        int k = 0;
        do
        begin
            @(posedge clock);
            #1;
            k = k + 1;
        end
        while (host_idle !== 1'b1 && k < 3000);
        if (k >= 3000)
            miscompares = miscompares + 1;
    endtask

    // Written word is pending one conversion, applied the next
    task automatic run_xfer(input logic [15:0] val, input logic [15:0] w);
        // Slow cycle time: every written word selects the asynchronous mode
        w[MODE_SEL_BIT] = 1'b1;
        wait_idle();
        check({16'h0, active_config}, {16'h0, act});
        @(posedge clock);
        sample_value <= val;
        cfg_word <= w;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        starts = starts + 1;
        exp_q.push_back(frame_of(val, act));
        act = pend;
        if (have_prev && wprev[15])
            pend = wprev;
        wprev = w;
        have_prev = 1'b1;
    endtask

    // ********
    // Clock, timeout, frame monitor
    // ********
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    always @(posedge clock)
    begin
        if (rand_ready)
            frame_ready <= 1'($urandom_range(0, 1));
        if (nrst && frame_valid === 1'b1 && frame_ready)
            check(frame_data, exp_q.size() ? exp_q.pop_front() : 32'hx);
        if (nrst && conversion_done === 1'b1)
            dones = dones + 1;
    end

    // ********
    // Main sequence
    // ********
    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        start = 1'b0;
        cfg_word = 16'h0000;
        sample_value = 16'h0000;
        frame_ready = 1'b1;
        act = CFG_RESET;
        pend = CFG_RESET;
        have_prev = 1'b0;
        rand_ready = 1'b0;
        void'($urandom(18));
        repeat (4) @(posedge clock);
        check({31'h0, asr_link_if_i.sdo_oe_n}, 32'h1);
        check({16'h0, active_config}, {16'h0, CFG_RESET});
        nrst <= 1'b1;
        $display("Test reset done");
        foreach (corner_val[i])
            run_xfer(corner_val[i], corner_cfg[i]);
        $display("Test corners done");
        repeat (20) run_xfer(16'($urandom), 16'($urandom));
        $display("Test random done");
        wait_idle();
        // Let the last random frame leave before the buffer is filled
        @(posedge clock);
        frame_ready <= 1'b0;
        repeat (16) run_xfer(16'($urandom), 16'($urandom));
        wait_idle();
        // Full buffer: the host must refuse a start rather than lose a frame
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (400) @(posedge clock);
        #1;
        check({31'h0, host_idle}, 32'h1);
        check({31'h0, asr_link_if_i.busy}, 32'h0);
        rand_ready = 1'b1;
        n = 0;
        while (exp_q.size() != 0 && n < 4000)
        begin
            @(posedge clock);
            n = n + 1;
        end
        rand_ready = 1'b0;
        frame_ready <= 1'b1;
        check(exp_q.size(), 32'h0);
        check(dones, starts);
        $display("Test fill and drain done");
        give_verdict();
    end
endmodule
